// File: irs_pkg.sv
`default_nettype none
// Shared constants and types for the serial register slave
package irs_pkg;

    // Register pointer values of the user registers
    localparam logic [7:0] OFS_FAULT_SOURCE = 8'h10;
    localparam logic [7:0] OFS_FAULT_MASK = 8'h11;
    localparam logic [7:0] OFS_REG_CTL_ONE = 8'h12;
    localparam logic [7:0] OFS_VOUT_TARGET = 8'h13;
    localparam logic [7:0] OFS_RAMP_CTL = 8'h14;
    localparam logic [7:0] OFS_BUS_CFG = 8'h15;

    // Values after reset or shutdown
    localparam logic [7:0] RST_FAULT_MASK = 8'h0f;
    localparam logic [7:0] RST_REG_CTL_ONE = 8'h50;
    localparam logic [7:0] RST_VOUT_TARGET = 8'h00;
    localparam logic [1:0] RST_SLEW_RATE = 2'h0;
    localparam logic RST_HOLD_BIT = 1'b0;
    localparam logic RST_HS_FILTER = 1'b0;

    // Field positions
    localparam int FAULT_BITS = 5;
    localparam int SLEW_MSB = 1;
    localparam int HOLD_POS = 0;

    // Address byte layout: fixed parts around the two select bits
    localparam logic [2:0] ADDR_TOP = 3'h6;
    localparam logic [1:0] ADDR_MID = 2'h3;
    localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
    localparam logic [4:0] MCODE_TOP = 5'h01;

    // Bit counter values: eight data bits, then the acknowledge clock
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [3:0] BIT_MSB = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_SKIP
    } irs_state_t;

    // Converter status flags, bit 4 down to bit 0
    typedef struct packed {
        logic pok;
        logic ovp;
        logic hard_short;
        logic thermal;
        logic overcurrent;
    } irs_fault_t;

    // Settings that the registers hand to the converter
    typedef struct packed {
        logic [7:0] fault_mask;
        logic [7:0] reg_ctl_one;
        logic [7:0] vout_target;
        logic [1:0] slew_rate;
        logic fast_mode_hold_bit;
    } irs_cfg_t;

    localparam irs_cfg_t RST_CFG = '{
        fault_mask: RST_FAULT_MASK,
        reg_ctl_one: RST_REG_CTL_ONE,
        vout_target: RST_VOUT_TARGET,
        slew_rate: RST_SLEW_RATE,
        fast_mode_hold_bit: RST_HOLD_BIT
    };

endpackage : irs_pkg
`default_nettype wire

// File: irs_reg_slave.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Acknowledge own address in ninth clock
// - Pointer byte follows address and is acknowledged
// - Acknowledge data, commit on ack rising edge
// - Sequential write bytes all accepted and acknowledged
// - Last sequential write byte also acknowledged
// - STOP returns filters to slow setting
// - Repeated START leaves filter setting alone
// - Shift eight pointer-selected bits, MSB first
// - Master acknowledge requests next register byte
// - Master code 00001xx0 selects high-speed filters
// - Master code answered with not-acknowledge
// - High speed lasts until a STOP
// - Hold bit keeps high speed across STOP
// - Shutdown returns all registers to reset
// - Never stretch the clock
// - Never acknowledge general call byte
// - Slow filters selected at power-up
module irs_reg_slave
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic shutdown,
    input wire logic [1:0] addr_sel,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire irs_pkg::irs_fault_t fault,
    output irs_pkg::irs_cfg_t cfg,
    output logic hs_filter_en
);

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    irs_pkg::irs_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic [7:0] rd_byte;
    logic master_ack;
    logic [6:0] own_addr;
    logic addr_hit;
    logic mcode_hit;
    logic commit;
    logic rd_load;
    logic [7:0] rd_value;

    // Both pins pass two flops; SCL is only ever sampled, never driven
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_pin};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    // Bus events seen from the second stage onward
    assign scl_rise = scl_sync[1] && !scl_prev;
    assign scl_fall = !scl_sync[1] && scl_prev;
    assign start_det = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    assign stop_det = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

    // Own address from the select pins; the all-zero byte never matches
    assign own_addr = {irs_pkg::ADDR_TOP, addr_sel[1], irs_pkg::ADDR_MID, addr_sel[0]};
    assign addr_hit = (shift[7:1] == own_addr) && (shift != irs_pkg::GEN_CALL_BYTE);
    assign mcode_hit = scl_fall && (bit_cnt == irs_pkg::BIT_LAST) && (state == irs_pkg::ST_ADDR)
        && (shift[7:3] == irs_pkg::MCODE_TOP) && !shift[0];

    // Write lands on the rising edge of the acknowledge clock
    assign commit = scl_rise && (bit_cnt == irs_pkg::BIT_ACK)
        && (state == irs_pkg::ST_WDATA);
    assign rd_load = scl_fall && (bit_cnt == irs_pkg::BIT_ACK) && (((state == irs_pkg::ST_ADDR)
        && sda_oe && shift[0]) || ((state == irs_pkg::ST_RDATA) && master_ack));

    // Read multiplexer on the current pointer; reserved bits read zero
    always_comb
    begin
        rd_value = 8'h00;
        unique case (pointer)
            irs_pkg::OFS_FAULT_SOURCE: rd_value = {3'h0, fault};
            irs_pkg::OFS_FAULT_MASK: rd_value = cfg.fault_mask;
            irs_pkg::OFS_REG_CTL_ONE: rd_value = cfg.reg_ctl_one;
            irs_pkg::OFS_VOUT_TARGET: rd_value = cfg.vout_target;
            irs_pkg::OFS_RAMP_CTL: rd_value = {6'h00, cfg.slew_rate};
            irs_pkg::OFS_BUS_CFG: rd_value = {7'h00, cfg.fast_mode_hold_bit};
            default: rd_value = 8'h00;
        endcase
    end

    // Byte engine: bit counting, shifting, acknowledge and data drive
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= irs_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rd_byte <= 8'h00;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_det)
        begin
            state <= irs_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end
        else if (start_det)
        begin
            // Plain and repeated START both restart address reception; filters kept
            state <= irs_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end
        else if (scl_rise && (state != irs_pkg::ST_IDLE) && (state != irs_pkg::ST_SKIP))
        begin
            if (bit_cnt < irs_pkg::BIT_LAST)
            begin
                shift <= {shift[6:0], sda_sync[1]};
                bit_cnt <= bit_cnt + 4'h1;
            end
            else if (bit_cnt == irs_pkg::BIT_ACK)
            begin
                master_ack <= !sda_sync[1];
            end
        end
        else if (scl_fall && (state != irs_pkg::ST_IDLE) && (state != irs_pkg::ST_SKIP))
        begin
            if (bit_cnt == irs_pkg::BIT_LAST)
            begin
                bit_cnt <= irs_pkg::BIT_ACK;
                unique case (state)
                    irs_pkg::ST_ADDR: sda_oe <= addr_hit;
                    irs_pkg::ST_PTR: sda_oe <= 1'b1;
                    irs_pkg::ST_WDATA: sda_oe <= 1'b1;
                    default: sda_oe <= 1'b0; // master answers a read byte
                endcase
            end
            else if (bit_cnt == irs_pkg::BIT_ACK)
            begin
                bit_cnt <= 4'h0;
                if (rd_load)
                begin
                    state <= irs_pkg::ST_RDATA;
                    rd_byte <= rd_value;
                    sda_oe <= !rd_value[7];
                end
                else
                begin
                    sda_oe <= 1'b0;
                    unique case (state)
                        irs_pkg::ST_ADDR: state <= sda_oe ? irs_pkg::ST_PTR : irs_pkg::ST_SKIP;
                        irs_pkg::ST_PTR: state <= irs_pkg::ST_WDATA;
                        irs_pkg::ST_WDATA: state <= irs_pkg::ST_WDATA;
                        default: state <= irs_pkg::ST_SKIP;
                    endcase
                end
            end
            else if (state == irs_pkg::ST_RDATA)
            begin
                // Next bit, most significant first, driven open-drain
                sda_oe <= !rd_byte[3'(irs_pkg::BIT_MSB - bit_cnt)];
            end
        end
    end

    // Register pointer: loaded from the pointer byte, stepped per data byte
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pointer <= 8'h00;
        end
        else if (scl_rise && (bit_cnt == irs_pkg::BIT_ACK) && (state == irs_pkg::ST_PTR))
        begin
            pointer <= shift;
        end
        else if (commit || rd_load)
        begin
            pointer <= pointer + 8'h01;
        end
    end

    // User registers; shutdown puts every one back to its reset value
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg <= irs_pkg::RST_CFG;
        end
        else if (shutdown)
        begin
            cfg <= irs_pkg::RST_CFG;
        end
        else if (commit)
        begin
            unique case (pointer)
                irs_pkg::OFS_FAULT_MASK: cfg.fault_mask <= shift;
                irs_pkg::OFS_REG_CTL_ONE: cfg.reg_ctl_one <= shift;
                irs_pkg::OFS_VOUT_TARGET: cfg.vout_target <= shift;
                irs_pkg::OFS_RAMP_CTL: cfg.slew_rate <= shift[irs_pkg::SLEW_MSB:0];
                irs_pkg::OFS_BUS_CFG:
                    cfg.fast_mode_hold_bit <= shift[irs_pkg::HOLD_POS];
                default: cfg <= cfg; // Status and unmapped pointers ignore writes
            endcase
        end
    end

    // Input filter mode: slow after reset, fast on master code, slow after STOP unless the hold bit is set
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hs_filter_en <= irs_pkg::RST_HS_FILTER;
        end
        else if (shutdown)
        begin
            hs_filter_en <= irs_pkg::RST_HS_FILTER;
        end
        else if (mcode_hit)
        begin
            hs_filter_en <= 1'b1;
        end
        else if (stop_det && !cfg.fast_mode_hold_bit)
        begin
            hs_filter_en <= 1'b0;
        end
    end

    // Open-drain: the data pin is only ever pulled low
    assign sda_out = 1'b0;

    // Checks on the protocol engine
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_addr_ack: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_ADDR && addr_hit
        |=> sda_oe && bit_cnt == 4'h9)
        else $error("own address not acknowledged");

    a_ptr_ack: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_PTR
        |=> sda_oe throughout (bit_cnt == 4'h9)[*2])
        else $error("pointer byte not acknowledged");

    a_wdata_commit: assert property (
        commit && pointer == irs_pkg::OFS_VOUT_TARGET && !shutdown
        |=> cfg.vout_target == $past(shift))
        else $error("data byte not committed on ack edge");

    a_wdata_ack: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_WDATA
        |=> sda_oe ##1 sda_oe)
        else $error("write data byte not acknowledged");

    a_stop_filter: assert property (
        stop_det && !cfg.fast_mode_hold_bit && !mcode_hit |=> !hs_filter_en)
        else $error("filters not slow after stop");

    a_rstart_filter: assert property (
        start_det && !shutdown |=> hs_filter_en == $past(hs_filter_en))
        else $error("repeated start changed filters");

    a_read_bit: assert property (
        scl_rise && state == irs_pkg::ST_RDATA && bit_cnt < 4'h8
        |-> sda_oe == !rd_byte[3'(4'h7 - bit_cnt)])
        else $error("read bit does not match register");

    a_mcode_nack: assert property (
        mcode_hit && !shutdown |=> !sda_oe && hs_filter_en)
        else $error("master code acknowledged or ignored");

    a_gen_call: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_ADDR && shift == 8'h00
        |=> !sda_oe)
        else $error("general call acknowledged");

    a_hold_keep: assert property (
        stop_det && cfg.fast_mode_hold_bit && hs_filter_en && !shutdown |=> hs_filter_en)
        else $error("hold bit did not keep high speed");

    a_shutdown_rst: assert property (
        shutdown |=> cfg == irs_pkg::RST_CFG && !hs_filter_en)
        else $error("shutdown did not reset registers");

    a_ptr_step: assert property (
        (commit || rd_load) |=> pointer == $past(pointer) + 8'h01)
        else $error("pointer did not step");

    a_foreign_nack: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_ADDR && !addr_hit |=> !sda_oe)
        else $error("foreign address acknowledged");

    a_ptr_load: assert property (
        scl_rise && bit_cnt == 4'h9 && state == irs_pkg::ST_PTR |=> pointer == $past(shift))
        else $error("pointer byte not loaded");

    a_rd_release: assert property (
        scl_fall && bit_cnt == 4'h8 && state == irs_pkg::ST_RDATA |=> !sda_oe)
        else $error("data line held during master ack");

    a_rd_next: assert property (
        rd_load && state == irs_pkg::ST_RDATA
        |=> state == irs_pkg::ST_RDATA && rd_byte == $past(rd_value))
        else $error("next read byte not loaded");

    a_stop_release: assert property (
        stop_det |=> !sda_oe && state == irs_pkg::ST_IDLE)
        else $error("data line held after stop");

    c_write: cover property (commit ##[1:200] commit);
    c_read_more: cover property (rd_load && state == irs_pkg::ST_RDATA);
    c_hs_entry: cover property (mcode_hit);
    c_hold_stop: cover property (stop_det && cfg.fast_mode_hold_bit && hs_filter_en);
    c_single_read: cover property (rd_load && state == irs_pkg::ST_ADDR);

endmodule : irs_reg_slave
`default_nettype wire

// File: irs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master model: makes the serial clock and pulls the data line low
module irs_master_model
(
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Bus idles released with the clock high
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Quarter of a 320 ns bus period, below the slow speed limit
    task automatic qw();
        repeat (2) @(negedge clk_sys);
    endtask : qw

    // START from idle, or repeated START from a low clock
    task automatic start();
        sda_pull = 1'b0;
        qw();
        scl = 1'b1;
        qw();
        sda_pull = 1'b1;
        qw();
        scl = 1'b0;
        qw();
    endtask : start

    // STOP, then a quiet gap with the clock standing high
    task automatic stop();
        sda_pull = 1'b1;
        qw();
        scl = 1'b1;
        qw();
        sda_pull = 1'b0;
        repeat (3) qw();
    endtask : stop

    // One bit: data set while the clock is low, sampled at the end of high
    task automatic bit_io(input logic v, output logic s);
        sda_pull = !v;
        qw();
        scl = 1'b1;
        qw();
        qw();
        s = sda;
        scl = 1'b0;
        qw();
    endtask : bit_io

    // Byte out, MSB first, then the ninth clock with the line released
    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : tx

    // Byte in; acknowledge asks for more, not-acknowledge ends the read
    task automatic rx(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(!more, s);
    endtask : rx
endmodule : irs_master_model
`default_nettype wire

// File: irs_reg_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irs_reg_slave_tb;
    logic clk_sys, rst_b, shutdown, scl_pin, sda_pull, sda_wire;
    logic sda_out, sda_oe, hs_filter_en, ack;
    logic [1:0] addr_sel;
    logic [7:0] rd;
    logic [7:0] mdl [6];
    irs_pkg::irs_fault_t fault;
    irs_pkg::irs_cfg_t cfg;
    int num_errors, tests_run, seed;

    // Open-drain data line with a pull-up
    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

    irs_master_model m (.clk_sys(clk_sys), .sda(sda_wire), .scl(scl_pin), .sda_pull(sda_pull));

    irs_reg_slave uut (.clk_sys(clk_sys), .rst_b(rst_b), .shutdown(shutdown),
        .addr_sel(addr_sel), .scl_pin(scl_pin), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .fault(fault), .cfg(cfg), .hs_filter_en(hs_filter_en));

    // 25 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // Expected register contents after reset or shutdown
    task automatic model_reset();
        mdl[0] = 8'h00;
        mdl[1] = irs_pkg::RST_FAULT_MASK;
        mdl[2] = irs_pkg::RST_REG_CTL_ONE;
        mdl[3] = irs_pkg::RST_VOUT_TARGET;
        mdl[4] = {6'h00, irs_pkg::RST_SLEW_RATE};
        mdl[5] = {7'h00, irs_pkg::RST_HOLD_BIT};
    endtask : model_reset

    function automatic logic [7:0] dev(input logic [1:0] s, input logic rw);
        return {3'h6, s[1], 2'h3, s[0], rw};
    endfunction : dev

    function automatic irs_pkg::irs_cfg_t exp_cfg();
        return {mdl[1], mdl[2], mdl[3], mdl[4][1:0], mdl[5][0]};
    endfunction : exp_cfg

    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        if (p == 8'h10)
            return {3'h0, fault};
        if (p > 8'h10 && p < 8'h16)
            return mdl[p - 8'h10];
        return 8'h00;
    endfunction : exp_rd

    // START, own address with write bit, pointer
    task automatic open_ptr(input logic [7:0] p);
        m.start();
        m.tx(dev(addr_sel, 1'b0), ack);
        check("address ack", ack, 1'b1);
        m.tx(p, ack);
        check("pointer ack", ack, 1'b1);
    endtask : open_ptr

    // Sequential write of n bytes, random or fixed data
    task automatic wr(input logic [7:0] p, input int n, input logic rnd, input logic [7:0] d);
        logic [7:0] v;
        open_ptr(p);
        for (int i = 0; i < n; i++)
        begin
            v = rnd ? 8'($random(seed)) : d;
            m.tx(v, ack);
            check("data ack", ack, 1'b1);
            if (p > 8'h10 && p < 8'h16)
                mdl[p - 8'h10] = v & (p == 8'h14 ? 8'h03 : (p == 8'h15 ? 8'h01 : 8'hff));
            check("cfg", cfg, exp_cfg());
            p = p + 8'h01;
        end
        m.stop();
    endtask : wr

    // Master code with random don't-care bits
    task automatic mcode();
        m.start();
        m.tx({irs_pkg::MCODE_TOP, 2'($random(seed)), 1'b0}, ack);
        m.qw();
        check("master code nack", ack, 1'b0);
        check("fast filters", hs_filter_en, 1'b1);
    endtask : mcode

    task automatic do_shutdown();
        shutdown = 1'b1;
        @(negedge clk_sys);
        shutdown = 1'b0;
        @(negedge clk_sys);
        model_reset();
        check("cfg shutdown", cfg, irs_pkg::RST_CFG);
        check("filters shutdown", hs_filter_en, 1'b0);
    endtask : do_shutdown

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        seed = 67;
        num_errors = 0;
        tests_run = 0;
        rst_b = 1'b0;
        shutdown = 1'b0;
        addr_sel = 2'h0;
        fault = '0;
        model_reset();
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("cfg reset", cfg, irs_pkg::RST_CFG);
        check("filters reset", hs_filter_en, 1'b0);
        check("open-drain level", sda_out, 1'b0);
        for (int k = 0; k < 5; k++)
        begin
            addr_sel = 2'($random(seed));
            fault = 5'($random(seed));
            wr(8'h10 + 8'(k), 3, 1'b1, 8'h00);
            open_ptr(8'h10);
            m.start();
            m.tx(dev(addr_sel, 1'b1), ack);
            check("read address ack", ack, 1'b1);
            for (int i = 0; i < 7; i++)
            begin
                m.rx(i < 6, rd);
                check("read data", rd, exp_rd(8'h10 + 8'(i)));
            end
            m.stop();
        end
        m.start();
        m.tx(dev(~addr_sel, 1'b0), ack);
        check("foreign address", ack, 1'b0);
        m.stop();
        m.start();
        m.tx(irs_pkg::GEN_CALL_BYTE, ack);
        check("general call", ack, 1'b0);
        m.stop();
        do_shutdown();
        mcode();
        wr(8'h13, 2, 1'b1, 8'h00);
        check("filters after stop", hs_filter_en, 1'b0);
        mcode();
        m.start();
        check("filters after repeated start", hs_filter_en, 1'b1);
        m.tx(dev(addr_sel, 1'b0), ack);
        check("fast address ack", ack, 1'b1);
        m.stop();
        wr(8'h15, 1, 1'b0, 8'h01);
        mcode();
        m.stop();
        check("filters kept", hs_filter_en, 1'b1);
        do_shutdown();
        finish_test();
    end
endmodule : irs_reg_slave_tb
`default_nettype wire
